// ---- logic/ossb_link.sv ----
`timescale 1ns/1ns
module ossb_link (
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_toggle,
  output logic miso
);
  logic [2:0] bit_q, bit_d;
  logic [6:0] sh_q, sh_d;
  logic [7:0] rxb_d;
  logic tgl_d;
  logic [6:0] tx_sh_q, tx_sh_d;
  logic miso_d;

  ////////////////////////////////////////////////////////////////////
  // sample on rising
  always_comb begin
    bit_d = bit_q + 3'h1;
    sh_d = {sh_q[5:0], mosi};
    rxb_d = rx_byte;
    tgl_d = rx_toggle;
    if (bit_q == 3'h7) begin
      rxb_d = {sh_q, mosi};
      tgl_d = ~rx_toggle;
    end
  end

  always_ff @(posedge sclk or posedge select_n) begin
    if (select_n) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      rx_byte <= 8'h00;
      rx_toggle <= 1'b0;
    end else begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_byte <= rxb_d;
      rx_toggle <= tgl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // shift out on falling
  always_comb begin
    if (bit_q == 3'h0) begin
      miso_d = tx_byte[7];
      tx_sh_d = tx_byte[6:0];
    end else begin
      miso_d = tx_sh_q[6];
      tx_sh_d = {tx_sh_q[5:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge select_n) begin
    if (select_n) begin
      tx_sh_q <= 7'h00;
      miso <= 1'b0;
    end else begin
      tx_sh_q <= tx_sh_d;
      miso <= miso_d;
    end
  end
endmodule

// ---- logic/ossb_pkg.sv ----
package ossb_pkg;
  // register addresses
  localparam logic [6:0] REG_ID = 7'h00;
  localparam logic [6:0] REG_CRC_LO = 7'h0C;
  localparam logic [6:0] REG_CRC_HI = 7'h0D;
  localparam logic [6:0] REG_CAPTURE = 7'h13;
  localparam logic [6:0] REG_FW_CTL = 7'h14;
  localparam logic [6:0] REG_FW_VER = 7'h1F;
  localparam logic [6:0] REG_ID_INV = 7'h3F;
  localparam logic [6:0] REG_PIX = 7'h40;
  localparam logic [6:0] REG_FW_LOAD = 7'h60;
  // control values
  localparam logic [7:0] FW_ARM = 8'h18;
  localparam logic [7:0] FW_SELFTEST = 8'h15;
  // arbitrary identification value
  localparam logic [7:0] ID_CODE = 8'h5A;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // field positions
  localparam int WR_BIT = 7;
  localparam int MARK_BIT = 6;
  // memory and stream sizes
  localparam int MEM_AW = 11;
  localparam int MEM_DEPTH = 2048;
  localparam logic [10:0] FW_LEN = 11'd1986;
  localparam logic [10:0] PIX_TOTAL = 11'd1536;
  localparam logic [10:0] PIX_FRAME = 11'd900;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int BEXIT_NS = 500;
  localparam int BEXIT_CYC = (BEXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RESYNC_US = 1000;
  localparam int RESYNC_CYC = RESYNC_US * CLK_MHZ;
  localparam int HI_W = 16;
  typedef enum logic [5:0] {
    ST_ADDR = 6'b000001,
    ST_WDATA = 6'b000010,
    ST_RDATA = 6'b000100,
    ST_LOAD = 6'b001000,
    ST_PIX = 6'b010000,
    ST_LOCK = 6'b100000
  } ossb_state_t;
endpackage

// ---- logic/ossb_port.sv ----
`timescale 1ns/1ns
// How it works
// - burst ends only after long select high
// - keep 1986 image bytes, drop rest
// - control value starts CRC self-test
// - capture kills navigation and firmware
// - capture trigger stores 1536 pixels
// - stream reads zero before data ready
// - 900 bytes frame, then 636 more
// - msb set, bit six marks frame
// - reads past stored data give zero
// - select high aborts stream read
// - long select high resyncs port only
// - unassigned writes ignored, reads zero
// - aborted transfer writes no register
// - reset pins: pull-ups off, laser off
// - power down stops oscillator, keeps registers
// - power down: pull-ups, laser off
// - address byte, msb one means write
// - sample rising, shift out falling
// - select high floats data output
module ossb_port
  import ossb_pkg::*;
#(
  parameter int RESYNC_CYCLES = RESYNC_CYC,
  parameter int BEXIT_CYCLES = BEXIT_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic power_down_n,
  input wire logic pix_valid,
  input wire logic pix_sof,
  input wire logic [5:0] pix_data,
  output logic miso,
  output logic miso_oe,
  output logic pullup_en,
  output logic laser_drive_oe,
  output logic laser_enable_n,
  output logic osc_run,
  output logic nav_en
);
  if (BEXIT_CYCLES < 1 || RESYNC_CYCLES <= BEXIT_CYCLES
      || RESYNC_CYCLES >= (1 << HI_W)) begin : g_chk
    $error("bad exit or resync count");
  end

  ////////////////////////////////////////////////////////////////////
  // link and crossings
  logic [7:0] rx_b, tx_q, tx_d, rdata, wdata;
  logic rx_tgl, tgl_s1, tgl_s2, tgl_s3;
  logic sel_s1, sel_s2, pdn_s1, pdn_s2;
  logic rx_evt, sel_hi, pd;
  logic [HI_W-1:0] hi_cnt_q, hi_cnt_d;

  ossb_link u_link (
    .sclk(sclk),
    .select_n(select_n),
    .mosi(mosi),
    .tx_byte(tx_q),
    .rx_byte(rx_b),
    .rx_toggle(rx_tgl),
    .miso(miso)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      pdn_s1 <= 1'b1;
      pdn_s2 <= 1'b1;
      hi_cnt_q <= '0;
    end else begin
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      sel_s1 <= select_n;
      sel_s2 <= sel_s1;
      pdn_s1 <= power_down_n;
      pdn_s2 <= pdn_s1;
      hi_cnt_q <= hi_cnt_d;
    end
  end

  assign sel_hi = sel_s2;
  assign pd = ~pdn_s2;
  assign rx_evt = (tgl_s2 ^ tgl_s3) & ~pd;
  always_comb begin
    hi_cnt_d = '0;
    if (sel_hi) begin
      hi_cnt_d = (&hi_cnt_q) ? hi_cnt_q : hi_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register state
  ossb_state_t state_q, state_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] fw_ctl_q, fw_ctl_d, fw_ver_q, fw_ver_d;
  logic [10:0] fw_cnt_q, fw_cnt_d, pix_ptr_q, pix_ptr_d;
  logic fw_loaded_q, fw_loaded_d, pix_ld_q, pix_ld_d;
  logic cap_start, st_start, fw_we;
  logic cap_busy_q, cap_busy_d, cap_ready_q, cap_ready_d;
  logic nav_off_q, nav_off_d, cap_we;
  logic [10:0] cap_idx_q, cap_idx_d, st_idx_q, st_idx_d;
  logic st_busy_q, st_busy_d, st_vld_q;
  logic [15:0] crc_q, crc_d;
  logic [7:0] cap_byte;
  logic [10:0] raddr, waddr;

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case (a)
      REG_ID: reg_read = ID_CODE;
      REG_ID_INV: reg_read = ~ID_CODE;
      REG_CRC_LO: reg_read = crc_q[7:0];
      REG_CRC_HI: reg_read = crc_q[15:8];
      REG_FW_VER: reg_read = fw_loaded_q ? fw_ver_q : 8'h00;
      REG_CAPTURE: reg_read = {7'h00, cap_ready_q};
      default: reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
    end
    crc_upd = r;
  endfunction

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    tx_d = tx_q;
    fw_cnt_d = fw_cnt_q;
    fw_ctl_d = fw_ctl_q;
    fw_ver_d = fw_ver_q;
    fw_loaded_d = fw_loaded_q;
    pix_ptr_d = pix_ptr_q;
    pix_ld_d = 1'b0;
    cap_start = 1'b0;
    st_start = 1'b0;
    fw_we = 1'b0;
    if (32'(hi_cnt_q) >= RESYNC_CYCLES) begin
      state_d = ST_ADDR;
      tx_d = 8'h00;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (rx_evt) begin
            addr_d = rx_b[6:0];
            if (rx_b[WR_BIT]) begin
              if (rx_b[6:0] == REG_FW_LOAD && fw_ctl_q == FW_ARM && !nav_off_q) begin
                state_d = ST_LOAD;
                fw_cnt_d = '0;
                fw_loaded_d = 1'b0;
              end else begin
                state_d = ST_WDATA;
              end
            end else if (rx_b[6:0] == REG_PIX) begin
              state_d = ST_PIX;
              pix_ptr_d = '0;
              pix_ld_d = 1'b1;
            end else begin
              state_d = ST_RDATA;
              tx_d = reg_read(rx_b[6:0]);
            end
          end
        end
        ST_WDATA: begin
          if (sel_hi) begin
            state_d = ST_ADDR;
          end else if (rx_evt) begin
            state_d = ST_ADDR;
            case (addr_q)
              REG_CAPTURE: cap_start = 1'b1;
              REG_FW_CTL: begin
                fw_ctl_d = rx_b;
                st_start = (rx_b == FW_SELFTEST);
              end
              default: ;
            endcase
          end
        end
        ST_RDATA: begin
          if (sel_hi || rx_evt) begin
            state_d = ST_ADDR;
          end
        end
        ST_LOAD: begin
          if (sel_hi) begin
            state_d = ST_LOCK;
          end else if (rx_evt && fw_cnt_q < FW_LEN) begin
            fw_we = 1'b1;
            fw_cnt_d = fw_cnt_q + 11'h001;
            if (fw_cnt_q == '0) begin
              fw_ver_d = rx_b;
            end
            if (fw_cnt_q == FW_LEN - 11'h001) begin
              fw_loaded_d = 1'b1;
            end
          end
        end
        ST_PIX: begin
          if (sel_hi) begin
            state_d = ST_LOCK;
          end else if (rx_evt) begin
            if (pix_ptr_q < PIX_TOTAL) begin
              pix_ptr_d = pix_ptr_q + 11'h001;
            end
            pix_ld_d = 1'b1;
          end
        end
        ST_LOCK: begin
          if (32'(hi_cnt_q) >= BEXIT_CYCLES) begin
            state_d = ST_ADDR;
          end
        end
        default: state_d = ST_ADDR;
      endcase
    end
    if (pix_ld_q) begin
      tx_d = (cap_ready_q && pix_ptr_q < PIX_TOTAL) ? rdata : 8'h00;
    end
    if (cap_start) begin
      fw_loaded_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_ADDR;
      addr_q <= '0;
      tx_q <= 8'h00;
      fw_cnt_q <= '0;
      fw_ctl_q <= 8'h00;
      fw_ver_q <= 8'h00;
      fw_loaded_q <= 1'b0;
      pix_ptr_q <= '0;
      pix_ld_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      fw_cnt_q <= fw_cnt_d;
      fw_ctl_q <= fw_ctl_d;
      fw_ver_q <= fw_ver_d;
      fw_loaded_q <= fw_loaded_d;
      pix_ptr_q <= pix_ptr_d;
      pix_ld_q <= pix_ld_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // capture and self-test
  // msb set, frame start mark
  assign cap_byte = {1'b1, (cap_idx_q == '0 || cap_idx_q == PIX_FRAME), pix_data};
  assign cap_we = cap_busy_q && pix_valid && (cap_idx_q != '0 || pix_sof);

  always_comb begin
    cap_busy_d = cap_busy_q;
    cap_ready_d = cap_ready_q;
    cap_idx_d = cap_idx_q;
    nav_off_d = nav_off_q;
    st_busy_d = st_busy_q;
    st_idx_d = st_idx_q;
    crc_d = crc_q;
    if (cap_start) begin
      cap_busy_d = 1'b1;
      cap_ready_d = 1'b0;
      cap_idx_d = '0;
      nav_off_d = 1'b1;
    end else if (cap_we) begin
      cap_idx_d = cap_idx_q + 11'h001;
      if (cap_idx_q == PIX_TOTAL - 11'h001) begin
        cap_busy_d = 1'b0;
        cap_ready_d = 1'b1;
      end
    end
    if (st_start) begin
      st_busy_d = 1'b1;
      st_idx_d = '0;
      crc_d = CRC_INIT;
    end else begin
      if (st_busy_q) begin
        st_idx_d = st_idx_q + 11'h001;
        st_busy_d = (st_idx_q != FW_LEN - 11'h001);
      end
      if (st_vld_q) begin
        crc_d = crc_upd(crc_q, rdata);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cap_busy_q <= 1'b0;
      cap_ready_q <= 1'b0;
      cap_idx_q <= '0;
      nav_off_q <= 1'b0;
      st_busy_q <= 1'b0;
      st_vld_q <= 1'b0;
      st_idx_q <= '0;
      crc_q <= 16'h0000;
    end else begin
      cap_busy_q <= cap_busy_d;
      cap_ready_q <= cap_ready_d;
      cap_idx_q <= cap_idx_d;
      nav_off_q <= nav_off_d;
      st_busy_q <= st_busy_d;
      st_vld_q <= st_busy_q;
      st_idx_q <= st_idx_d;
      crc_q <= crc_d;
    end
  end

  assign raddr = st_busy_q ? st_idx_q : pix_ptr_d;
  assign waddr = cap_we ? cap_idx_q : fw_cnt_q;
  assign wdata = cap_we ? cap_byte : rx_b;

  ossb_store #(.AW(MEM_AW), .DEPTH(MEM_DEPTH)) u_store (
    .sys_clk(sys_clk),
    .we(cap_we | fw_we),
    .waddr(waddr),
    .wdata(wdata),
    .raddr(raddr),
    .rdata(rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // pin states
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      miso_oe <= 1'b0;
      pullup_en <= 1'b0;
      laser_drive_oe <= 1'b0;
      laser_enable_n <= 1'b1;
      osc_run <= 1'b1;
      nav_en <= 1'b0;
    end else begin
      miso_oe <= ~sel_hi;
      pullup_en <= ~pd;
      laser_drive_oe <= ~pd;
      laser_enable_n <= pd;
      osc_run <= ~pd;
      nav_en <= fw_loaded_q & ~nav_off_q & ~pd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_load_discard: assert property (state_q == ST_LOAD && fw_cnt_q >= FW_LEN |-> !fw_we)
    else $error("byte past image stored");
  chk_burst_lock: assert property (state_q == ST_LOCK
      && 32'(hi_cnt_q) < BEXIT_CYCLES |=> state_q == ST_LOCK)
    else $error("burst lock left early");
  chk_pix_zero: assert property (pix_ld_q && !cap_ready_q |=> tx_q == 8'h00)
    else $error("stream data before ready");
  chk_pix_end: assert property (pix_ld_q && pix_ptr_q >= PIX_TOTAL |=> tx_q == 8'h00)
    else $error("stream data past end");
  chk_pix_mark: assert property (cap_we |-> wdata[7]
      && wdata[MARK_BIT] == (cap_idx_q == '0 || cap_idx_q == PIX_FRAME))
    else $error("pixel marker wrong");
  chk_cap_count: assert property ($fell(cap_busy_q) |-> cap_idx_q == PIX_TOTAL && cap_ready_q)
    else $error("capture count wrong");
  chk_nav_kill: assert property (cap_start |-> ##[1:2] !nav_en)
    else $error("navigation kept after capture");
  chk_abort_write: assert property (state_q == ST_WDATA && sel_hi
      |-> !cap_start && !st_start ##1 state_q == ST_ADDR && $stable(fw_ctl_q))
    else $error("aborted write took effect");
  chk_reset_pins: assert property (disable iff (1'b0) srst |=> !pullup_en
      && laser_enable_n && !laser_drive_oe)
    else $error("reset pin state wrong");
  chk_pd_pins: assert property (pd ##1 pd |=> !pullup_en && laser_enable_n && !osc_run)
    else $error("power down pin state wrong");
  chk_miso_float: assert property (sel_hi |=> !miso_oe)
    else $error("output driven while deselected");
  chk_selftest_len: assert property ($fell(st_busy_q) |-> st_idx_q == FW_LEN)
    else $error("self-test length wrong");

  cov_pix_burst: cover property (state_q == ST_PIX && cap_ready_q && rx_evt);
  cov_load_done: cover property ($rose(fw_loaded_q));
  cov_selftest: cover property ($fell(st_busy_q));
  cov_abort_write: cover property (state_q == ST_WDATA && sel_hi);
endmodule

// ---- logic/ossb_store.sv ----
`timescale 1ns/1ns
module ossb_store #(
  parameter int AW = 11,
  parameter int DEPTH = 2048
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("depth exceeds address range");
  end
  // shared by firmware image and captured pixels
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- sim/ossb_host.sv ----
`timescale 1ns/1ns
module ossb_host (
  output logic sclk,
  output logic select_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic line;
  // released data output floats to the pull-up level
  assign line = miso_oe ? miso : 1'b1;
  initial begin
    sclk = 1'b1;
    select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic sel(input logic v);
    #7;
    select_n = v;
    #100;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #40;
      sclk = 1'b1;
      rx[i] = line;
      #40;
    end
    mosi = ~mosi;
    #240;
  endtask
endmodule

// ---- sim/ossb_port_tb.sv ----
`timescale 1ns/1ns
module ossb_port_tb
  import ossb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst;
  logic power_down_n;
  logic pix_valid;
  logic pix_sof;
  logic [5:0] pix_data;
  logic sclk;
  logic select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic pullup_en;
  logic laser_drive_oe;
  logic laser_enable_n;
  logic osc_run;
  logic nav_en;
  logic [7:0] d;
  int err_count = 0;
  int checked = 0;

  always #10 sys_clk = ~sys_clk;

  ossb_port #(.RESYNC_CYCLES(100), .BEXIT_CYCLES(25)) dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .sclk(sclk),
    .select_n(select_n),
    .mosi(mosi),
    .power_down_n(power_down_n),
    .pix_valid(pix_valid),
    .pix_sof(pix_sof),
    .pix_data(pix_data),
    .miso(miso),
    .miso_oe(miso_oe),
    .pullup_en(pullup_en),
    .laser_drive_oe(laser_drive_oe),
    .laser_enable_n(laser_enable_n),
    .osc_run(osc_run),
    .nav_en(nav_en)
  );

  ossb_host host (
    .sclk(sclk),
    .select_n(select_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
    logic [7:0] junk;
    host.sel(1'b0);
    host.xfer({1'b0, a}, junk);
    host.xfer(8'h00, v);
    host.sel(1'b1);
    idle(8);
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] junk;
    host.sel(1'b0);
    host.xfer({1'b1, a}, junk);
    host.xfer(v, junk);
    host.sel(1'b1);
    idle(8);
  endtask
  function automatic logic [5:0] pv(input int f, input int i);
    return 6'((i * 3 + f * 5) % 64);
  endfunction
  function automatic logic [7:0] pix_exp(input int n);
    int f;
    int i;
    if (n >= 1536) begin
      return 8'h00;
    end
    f = (n < 900) ? 0 : 1;
    i = n - f * 900;
    return {1'b1, i == 0, pv(f, i)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1900000;
    err_count++;
    close_out();
  end

  initial begin
    srst <= 1'b1;
    power_down_n <= 1'b1;
    pix_valid <= 1'b0;
    pix_sof <= 1'b0;
    pix_data <= 6'h00;
    idle(3);
    check("pullup_en", {7'h00, pullup_en}, 8'h00);
    check("laser_drive_oe", {7'h00, laser_drive_oe}, 8'h00);
    check("laser_enable_n", {7'h00, laser_enable_n}, 8'h01);
    @(posedge sys_clk);
    @(posedge sys_clk);
    srst <= 1'b0;
    idle(5);
    check("pullup_en", {7'h00, pullup_en}, 8'h01);
    check("laser_drive_oe", {7'h00, laser_drive_oe}, 8'h01);
    check("laser_enable_n", {7'h00, laser_enable_n}, 8'h00);
    check("nav_en", {7'h00, nav_en}, 8'h00);
    check("miso_oe", {7'h00, miso_oe}, 8'h00);
    host.sel(1'b0);
    idle(5);
    check("miso_oe", {7'h00, miso_oe}, 8'h01);
    host.sel(1'b1);
    idle(5);
    check("miso_oe", {7'h00, miso_oe}, 8'h00);
    reg_rd(REG_ID, d);
    check("id", d, ID_CODE);
    reg_rd(REG_ID_INV, d);
    check("id_inv", d, ~ID_CODE);
    host.sel(1'b0);
    host.xfer({1'b0, REG_ID}, d);
    host.sel(1'b1);
    idle(8);
    reg_rd(REG_ID, d);
    check("id after abort", d, ID_CODE);
    reg_wr(7'h05, 8'hFF);
    reg_rd(7'h05, d);
    check("unassigned", d, 8'h00);
    reg_rd(7'h7E, d);
    check("unassigned", d, 8'h00);
    reg_wr(REG_FW_CTL, 8'h1D);
    idle(20);
    reg_wr(REG_FW_CTL, FW_ARM);
    host.sel(1'b0);
    host.xfer({1'b1, REG_FW_LOAD}, d);
    for (int k = 0; k < 4; k++) begin
      host.xfer(8'hA7 + 8'(k), d);
    end
    host.sel(1'b1);
    reg_rd(REG_ID, d);
    check("id during lock", d, 8'h00);
    idle(40);
    reg_rd(REG_ID, d);
    check("id after burst", d, ID_CODE);
    idle(120);
    reg_rd(REG_ID_INV, d);
    check("id after resync", d, ~ID_CODE);
    @(posedge sys_clk);
    power_down_n <= 1'b0;
    idle(8);
    check("osc_run", {7'h00, osc_run}, 8'h00);
    check("pullup_en", {7'h00, pullup_en}, 8'h00);
    check("laser_drive_oe", {7'h00, laser_drive_oe}, 8'h00);
    check("laser_enable_n", {7'h00, laser_enable_n}, 8'h01);
    @(posedge sys_clk);
    power_down_n <= 1'b1;
    idle(8);
    check("osc_run", {7'h00, osc_run}, 8'h01);
    check("pullup_en", {7'h00, pullup_en}, 8'h01);
    reg_rd(REG_ID, d);
    check("id after wake", d, ID_CODE);
    reg_wr(REG_CAPTURE, 8'h00);
    check("nav_en", {7'h00, nav_en}, 8'h00);
    reg_rd(REG_CAPTURE, d);
    check("capture ready", d, 8'h00);
    host.sel(1'b0);
    host.xfer({1'b0, REG_PIX}, d);
    for (int k = 0; k < 2; k++) begin
      host.xfer(8'h00, d);
      check("early pixel", d, 8'h00);
    end
    host.sel(1'b1);
    idle(40);
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 900; i++) begin
        @(posedge sys_clk);
        pix_valid <= 1'b1;
        pix_sof <= (i == 0);
        pix_data <= pv(f, i);
        @(posedge sys_clk);
        pix_valid <= 1'b0;
      end
    end
    idle(4);
    reg_rd(REG_CAPTURE, d);
    check("capture ready", d, 8'h01);
    host.sel(1'b0);
    host.xfer({1'b1, REG_CAPTURE}, d);
    host.sel(1'b1);
    idle(8);
    reg_rd(REG_CAPTURE, d);
    check("ready after abort", d, 8'h01);
    host.sel(1'b0);
    host.xfer({1'b0, REG_PIX}, d);
    for (int n = 0; n < 1540; n++) begin
      host.xfer(8'h00, d);
      check("pixel", d, pix_exp(n));
    end
    host.sel(1'b1);
    idle(40);
    reg_wr(REG_FW_CTL, FW_SELFTEST);
    idle(2100);
    reg_rd(REG_FW_VER, d);
    check("version after capture", d, 8'h00);
    reg_rd(REG_ID, d);
    check("id after pixel burst", d, ID_CODE);
    close_out();
  end
endmodule
